// >>> src/interrupt_reset_control.sv
// Interrupt priority, vectoring, low-power and reset control.
// Assumes a CPU core that reports instruction ends and a classic
// Wishbone master for the periodic tick and pending registers.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module interrupt_reset_control
   import irc_pkg::*;
#(
   parameter bit         LEVEL_TRIG = 1'b1,
   parameter logic [1:0] TICK_SEL   = TICK_1S,
   parameter bit         STOP_OK    = 1'b1
)(
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   // CPU core
   input  wire logic        cpu_mask_in,
   input  wire logic        cpu_instr_done_in,
   input  wire logic        cpu_trap_fetch_in,
   input  wire logic        cpu_stop_in,
   input  wire logic        cpu_wait_in,
   output logic             svc_take_out,
   output logic [12:0]      svc_vector_out,
   output logic             cpu_clk_en_out,
   // Interrupt sources
   input  wire logic        irq_pin_n_in,
   input  wire logic        timer_ovf_flag_in,
   input  wire logic        timer_ovf_en_in,
   input  wire logic        timer_rt_flag_in,
   input  wire logic        timer_rt_en_in,
   input  wire logic        serial_flag_in,
   input  wire logic        serial_en_in,
   input  wire logic        twowire_flag_in,
   input  wire logic        twowire_en_in,
   input  wire logic        slow_crystal_input_in,
   // Oscillator and timer
   output logic             osc_run_out,
   output logic             timer_clear_out,
   // Reset sources and pin
   input  wire logic        power_up_in,
   input  wire logic        watchdog_reset_in,
   input  wire logic        illegal_fetch_in,
   input  wire logic        rst_pin_n_in,
   output logic             rst_pin_out,
   output logic             rst_pin_oe_n_out,
   output logic             internal_rst_out,
   output logic             mode_sample_out
);

   // ****************************************
   // Decoding functions
   // ****************************************
   function automatic src_t pick_src(input logic [4:0] p);
      src_t s;
      s = SRC_NONE;
      if (p[4]) s = SRC_TWOWIRE;
      if (p[3]) s = SRC_SERIAL;
      if (p[2]) s = SRC_TICK;
      if (p[1]) s = SRC_TIMER;
      if (p[0]) s = SRC_EXT;
      return s;
   endfunction : pick_src

   function automatic logic [12:0] vec_of(input src_t s);
      logic [12:0] v;
      v = VEC_RESET;
      unique case (s)
         SRC_EXT:     v = VEC_EXT;
         SRC_TIMER:   v = VEC_TIMER;
         SRC_TICK:    v = VEC_TICK;
         SRC_SERIAL:  v = VEC_SERIAL;
         SRC_TWOWIRE: v = VEC_TWOWIRE;
         SRC_TRAP:    v = VEC_TRAP;
         SRC_NONE:    v = VEC_RESET;
      endcase
      return v;
   endfunction : vec_of

   // ****************************************
   // State
   // ****************************************
   logic        irq_prev_reg, ext_latch_reg, ext_pipe1_reg, ext_pipe2_reg;
   logic [4:0]  snap_reg;
   logic        trap_pend_reg;
   logic        tick_flag_reg, tick_en_reg;
   pwr_t        pwr_reg, pwr_next;
   logic [11:0] stab_cnt_reg, por_cnt_reg;
   logic        por_busy_reg, stop_rst_reg, ext_hold_reg, src_prev_reg;
   logic        wd_prev_reg;
   logic [2:0]  pull_cnt_reg;
   logic        tick_roll;

   // ****************************************
   // Request decode
   // ****************************************
   wire        irq_fall  = irq_prev_reg & ~irq_pin_n_in;
   wire        ext_req   = ext_pipe2_reg | (LEVEL_TRIG & ~irq_pin_n_in);
   wire        timer_req = (timer_ovf_flag_in & timer_ovf_en_in)
                         | (timer_rt_flag_in & timer_rt_en_in);
   wire        tick_req  = tick_flag_reg & tick_en_reg;
   wire [4:0]  hw_pend   = {twowire_flag_in & twowire_en_in,
                            serial_flag_in & serial_en_in,
                            tick_req, timer_req, ext_req};
   wire [4:0]  live      = hw_pend & ~{5{cpu_mask_in}};
   wire [4:0]  early     = snap_reg & live;
   // Trap waits behind requests seen at its fetch
   wire src_t  choice    = (trap_pend_reg && early != 5'h00) ? pick_src(early) :
                           trap_pend_reg ? SRC_TRAP : pick_src(live);
   wire        take      = cpu_instr_done_in && choice != SRC_NONE;
   wire        take_ext  = take && choice == SRC_EXT;
   wire [4:0]  take_bit  = 5'(1 << choice);

   // ****************************************
   // Low-power sequencing
   // ****************************************
   wire ext_seen  = ~rst_pin_n_in & rst_pin_oe_n_out;
   wire wake_wait = ext_req | (|hw_pend[4:1]);
   wire stab_done = stab_cnt_reg == STAB_LAST;

   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         PWR_RUN:  if (cpu_stop_in && STOP_OK) pwr_next = PWR_STOP;
                   else if (cpu_wait_in) pwr_next = PWR_WAIT;
         PWR_WAIT: if (wake_wait) pwr_next = PWR_RUN;
         PWR_STOP: if (ext_req || ext_seen) pwr_next = PWR_STAB;
         PWR_STAB: if (stab_done) pwr_next = PWR_RUN;
      endcase
   end

   wire enter_stop = pwr_reg == PWR_RUN && pwr_next == PWR_STOP;
   wire leave_stab = pwr_reg == PWR_STAB && stab_done;

   // ****************************************
   // Reset sources and pin
   // ****************************************
   wire int_src   = watchdog_reset_in | illegal_fetch_in
                  | stop_rst_reg | por_busy_reg;
   wire src_any   = int_src | ext_hold_reg;
   wire pull_go   = src_any & ~src_prev_reg;
   wire drive     = pull_go | (pull_cnt_reg > PULL_HOLD) | int_src;
   wire por_done  = por_cnt_reg == STAB_LAST;

   // ****************************************
   // Register access
   // ****************************************
   wire       wb_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire       hit_csr = wb_adr_in[7:2] == IDX_TICK_CSR;
   wire       hit_pnd = wb_adr_in[7:2] == IDX_PENDING;
   wire       wr_csr  = wb_req & wb_we_in & wb_sel_in[0] & hit_csr;
   wire       flag_wz = wr_csr & ~wb_dat_in[TICK_FLAG_BIT];
   wire [7:0] csr_rd  = {tick_flag_reg, tick_en_reg, 6'h00};
   wire [7:0] pnd_rd  = {1'b0, pwr_reg, trap_pend_reg, 1'b0, hw_pend[2:0]};
   wire [31:0] rd_mux = hit_csr ? {24'h000000, csr_rd} :
                        hit_pnd ? {24'h000000, pnd_rd} : 32'h00000000;

   periodic_tick_counter #(
      .TICK_SEL (TICK_SEL)
   ) u_tick (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .clear_in   (internal_rst_out),
      .run_in     (osc_run_out),
      .slow_in    (slow_crystal_input_in),
      .roll_out   (tick_roll)
   );

   // ****************************************
   // Interrupt logic
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_prev_reg   <= 1'b1;
         ext_latch_reg  <= 1'b0;
         ext_pipe1_reg  <= 1'b0;
         ext_pipe2_reg  <= 1'b0;
         snap_reg       <= 5'h00;
         trap_pend_reg  <= 1'b0;
         svc_take_out   <= 1'b0;
         svc_vector_out <= VEC_RESET;
      end else begin
         irq_prev_reg  <= irq_pin_n_in;
         // New edge wins over the service clear
         ext_latch_reg <= irq_fall | (ext_latch_reg & ~take_ext);
         ext_pipe1_reg <= ext_latch_reg & ~take_ext;
         ext_pipe2_reg <= ext_pipe1_reg & ~take_ext;
         if (cpu_trap_fetch_in) begin
            trap_pend_reg <= 1'b1;
            snap_reg      <= live;
         end else if (take) begin
            trap_pend_reg <= trap_pend_reg & (choice != SRC_TRAP);
            snap_reg      <= snap_reg & ~take_bit;
         end
         svc_take_out <= take;
         if (take) begin
            svc_vector_out <= vec_of(choice);
         end
      end
   end

   // ****************************************
   // Periodic register and bus
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || internal_rst_out) begin
         tick_flag_reg <= TICK_CSR_RST[TICK_FLAG_BIT];
         tick_en_reg   <= TICK_CSR_RST[TICK_EN_BIT];
      end else begin
         tick_flag_reg <= tick_roll | (tick_flag_reg & ~flag_wz);
         if (wr_csr) begin
            tick_en_reg <= wb_dat_in[TICK_EN_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= wb_req;
         wb_dat_out <= wb_req ? rd_mux : 32'h00000000;
      end
   end

   // ****************************************
   // Power modes
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pwr_reg         <= PWR_RUN;
         stab_cnt_reg    <= 12'h000;
         osc_run_out     <= 1'b1;
         cpu_clk_en_out  <= 1'b1;
         timer_clear_out <= 1'b0;
      end else begin
         pwr_reg         <= pwr_next;
         stab_cnt_reg    <= (pwr_reg == PWR_STAB) ? stab_cnt_reg + 12'h001 : 12'h000;
         osc_run_out     <= pwr_next != PWR_STOP;
         cpu_clk_en_out  <= pwr_next == PWR_RUN;
         timer_clear_out <= enter_stop | leave_stab;
      end
   end

   // ****************************************
   // Reset control
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         por_busy_reg     <= 1'b1;
         por_cnt_reg      <= 12'h000;
         stop_rst_reg     <= 1'b0;
         ext_hold_reg     <= 1'b0;
         src_prev_reg     <= 1'b0;
         wd_prev_reg      <= 1'b0;
         pull_cnt_reg     <= 3'h0;
         rst_pin_out      <= 1'b0;
         rst_pin_oe_n_out <= 1'b1;
         internal_rst_out <= 1'b1;
         mode_sample_out  <= 1'b0;
      end else begin
         if (power_up_in) begin
            por_busy_reg <= 1'b1;
            por_cnt_reg  <= 12'h000;
         end else if (por_busy_reg) begin
            por_busy_reg <= ~por_done;
            por_cnt_reg  <= por_cnt_reg + 12'h001;
         end
         stop_rst_reg     <= cpu_stop_in && !STOP_OK && pwr_reg == PWR_RUN;
         ext_hold_reg     <= ~rst_pin_n_in & (ext_hold_reg | ext_seen);
         src_prev_reg     <= src_any;
         wd_prev_reg      <= watchdog_reset_in;
         pull_cnt_reg     <= pull_go ? PULL_LOAD :
                             (pull_cnt_reg != 3'h0) ? pull_cnt_reg - 3'h1 : 3'h0;
         rst_pin_oe_n_out <= ~drive;
         internal_rst_out <= src_any;
         mode_sample_out  <= (ext_hold_reg & rst_pin_n_in)
                           | (wd_prev_reg & ~watchdog_reset_in);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   logic [11:0] low_cnt_reg;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || pwr_reg != PWR_STAB) low_cnt_reg <= 12'h000;
      else low_cnt_reg <= low_cnt_reg + 12'h001;
   end

   sequence trap_alone;
      cpu_instr_done_in && trap_pend_reg && early == 5'h00;
   endsequence

   a_trap_unmasked: assert property (
      trap_alone |=> svc_take_out && svc_vector_out == VEC_TRAP)
      else $error("trap not taken");
   a_mask_blocks: assert property (
      cpu_instr_done_in && cpu_mask_in && !trap_pend_reg |=> !svc_take_out)
      else $error("masked request taken");
   a_ext_first: assert property (
      cpu_instr_done_in && !cpu_mask_in && !trap_pend_reg && ext_req && timer_req
      |=> svc_vector_out == VEC_EXT)
      else $error("external not first");
   a_tick_order: assert property (
      cpu_instr_done_in && !cpu_mask_in && !trap_pend_reg && hw_pend[1:0] == 2'h0
      && tick_req && hw_pend[3] |=> svc_vector_out == VEC_TICK)
      else $error("periodic order wrong");
   a_flag_set_wins: assert property (
      tick_roll && !internal_rst_out |=> tick_flag_reg)
      else $error("rollover lost");
   a_flag_clears: assert property (
      flag_wz && !tick_roll |=> !tick_flag_reg)
      else $error("flag not cleared");
   a_pull_length: assert property (
      pull_go |=> !rst_pin_oe_n_out [*4])
      else $error("pulldown too short");
   a_stab_wait: assert property (
      $rose(timer_clear_out) && $past(pwr_reg) == PWR_STAB
      |-> $past(low_cnt_reg) == STAB_LAST)
      else $error("stabilization count wrong");
   a_wait_wake: assert property (
      pwr_reg == PWR_WAIT && wake_wait |=> ##[0:1] cpu_clk_en_out)
      else $error("wait not ended");
   a_por_holds: assert property (
      por_busy_reg |=> internal_rst_out)
      else $error("power-up reset released");

endmodule : interrupt_reset_control

// >>> include/irc_pkg.sv
// Constants and types shared by the interrupt and reset controller.
// Assumes a 10 MHz system clock and a 32 kHz slow input sampled on it.
package irc_pkg;

   // ****************************************
   // Service routine vector addresses
   // ****************************************
   localparam logic [12:0] VEC_RESET   = 13'h1ffe;
   localparam logic [12:0] VEC_TRAP    = 13'h1ffc;
   localparam logic [12:0] VEC_EXT     = 13'h1ffa;
   localparam logic [12:0] VEC_TIMER   = 13'h1ff8;
   localparam logic [12:0] VEC_TICK    = 13'h1ff6;
   localparam logic [12:0] VEC_SERIAL  = 13'h1ff4;
   localparam logic [12:0] VEC_TWOWIRE = 13'h1ff2;

   // ****************************************
   // Register indices, byte address is four times these
   // ****************************************
   localparam logic [5:0] IDX_TICK_CSR = 6'h12;
   localparam logic [5:0] IDX_PENDING  = 6'h13;
   localparam int         TICK_FLAG_BIT = 7;
   localparam int         TICK_EN_BIT   = 6;
   localparam logic [7:0] TICK_CSR_RST  = 8'h00;

   // ****************************************
   // Timing counts in internal clock cycles
   // ****************************************
   localparam int          STAB_CYCLES = 4064;
   localparam logic [11:0] STAB_LAST   = 12'(STAB_CYCLES - 1);
   localparam int          PULL_CYCLES = 4;
   localparam logic [2:0]  PULL_LOAD   = 3'(PULL_CYCLES);
   localparam logic [2:0]  PULL_HOLD   = 3'h1;

   // ****************************************
   // Periodic tick period selection
   // ****************************************
   localparam logic [1:0]  TICK_QTR  = 2'h0;
   localparam logic [1:0]  TICK_HALF = 2'h1;
   localparam logic [1:0]  TICK_1S   = 2'h2;
   localparam logic [14:0] MASK_QTR  = 15'h1fff;
   localparam logic [14:0] MASK_HALF = 15'h3fff;
   localparam logic [14:0] MASK_1S   = 15'h7fff;

   typedef enum logic [2:0] {
      SRC_EXT, SRC_TIMER, SRC_TICK, SRC_SERIAL, SRC_TWOWIRE, SRC_TRAP, SRC_NONE
   } src_t;

   typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP, PWR_STAB} pwr_t;

endpackage : irc_pkg

// >>> src/periodic_tick_counter.sv
// 15-bit periodic tick counter stepped by rising edges of the slow input.
// Assumes slow_in is already synchronous to sys_clk_in.
`timescale 1ns/1ps
module periodic_tick_counter
   import irc_pkg::*;
#(
   parameter logic [1:0] TICK_SEL = TICK_1S
)(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // Control
   input  wire logic clear_in,
   input  wire logic run_in,
   input  wire logic slow_in,
   // Tick
   output logic      roll_out
);

   logic        slow_prev_reg;
   logic [14:0] count_reg;
   logic [14:0] count_next;
   logic [14:0] roll_mask;
   wire         slow_rise = slow_in & ~slow_prev_reg;
   wire         step      = slow_rise & run_in;

   assign roll_mask  = (TICK_SEL == TICK_QTR)  ? MASK_QTR :
                       (TICK_SEL == TICK_HALF) ? MASK_HALF : MASK_1S;
   assign count_next = count_reg + 15'h0001;

   // ****************************************
   // Counter, frozen while the oscillator is off
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || clear_in) begin
         // Track the input so no false edge follows reset
         slow_prev_reg <= slow_in;
         count_reg     <= 15'h0000;
         roll_out      <= 1'b0;
      end else begin
         slow_prev_reg <= slow_in;
         if (step) begin
            count_reg <= count_next;
         end
         roll_out <= step && ((count_reg & roll_mask) == roll_mask);
      end
   end

endmodule : periodic_tick_counter

// >>> tb/cpu_model.sv
// Behavioural CPU core: ends an instruction every fourth running cycle.
// Assumes the controller's take pulse and vector outputs.
`timescale 1ns/1ps
module cpu_model (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // Controller side
   input  wire logic        clk_en_in,
   input  wire logic        take_in,
   input  wire logic [12:0] vector_in,
   output logic             done_out,
   // Bench side
   output logic [12:0]      last_vec_out,
   output logic [7:0]       takes_out
);
   logic [1:0] phase_reg;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         phase_reg    <= 2'h0;
         done_out     <= 1'b0;
         last_vec_out <= 13'h0;
         takes_out    <= 8'h0;
      end else begin
         // Instructions end only while clocked
         if (clk_en_in) begin
            phase_reg <= phase_reg + 2'h1;
         end
         done_out <= clk_en_in && (phase_reg == 2'h3);
         if (take_in) begin
            last_vec_out <= vector_in;
            takes_out    <= takes_out + 8'h1;
         end
      end
   end
endmodule : cpu_model

// >>> tb/interrupt_reset_control_test.sv
// Self-checking bench for the interrupt and reset controller.
// Assumes the CPU model and a fast slow input toggling every 2 cycles.
`timescale 1ns/1ps
module interrupt_reset_control_test;
   import irc_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, we = 0, irq_n = 1, t_of = 0, t_rt = 0, t_en = 0;
   logic ser_f = 0, ser_e = 0, tw_f = 0, tw_e = 0, slow = 0, mask = 1, trap = 0;
   logic stp = 0, wt = 0, pwr = 1, wdog = 0, ill = 0, ext_n = 1, seen;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat_o, r;
   logic ack, take, clk_en, done, osc, tclr, pin_o, oe_n, irst, msamp;
   logic [12:0] vec, lvec;
   logic [7:0] ntk;
   wire pin_n = ext_n & (oe_n | pin_o);
   int miscompares = 0, n_compared = 0, cyc_n = 0, k;

   interrupt_reset_control #(.TICK_SEL(TICK_QTR)) i_dut (
      .sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(dat_o), .wb_ack_out(ack), .cpu_mask_in(mask),
      .cpu_instr_done_in(done), .cpu_trap_fetch_in(trap), .cpu_stop_in(stp),
      .cpu_wait_in(wt), .svc_take_out(take), .svc_vector_out(vec),
      .cpu_clk_en_out(clk_en), .irq_pin_n_in(irq_n), .timer_ovf_flag_in(t_of),
      .timer_ovf_en_in(t_en), .timer_rt_flag_in(t_rt), .timer_rt_en_in(t_en),
      .serial_flag_in(ser_f), .serial_en_in(ser_e), .twowire_flag_in(tw_f),
      .twowire_en_in(tw_e), .slow_crystal_input_in(slow), .osc_run_out(osc),
      .timer_clear_out(tclr), .power_up_in(pwr), .watchdog_reset_in(wdog),
      .illegal_fetch_in(ill), .rst_pin_n_in(pin_n), .rst_pin_out(pin_o),
      .rst_pin_oe_n_out(oe_n), .internal_rst_out(irst), .mode_sample_out(msamp));

   cpu_model i_cpu (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
      .take_in(take), .vector_in(vec), .done_out(done), .last_vec_out(lvec),
      .takes_out(ntk));

   always #50 clk = ~clk;
   always #200 slow = ~slow;

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic conclude;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   function automatic logic [31:0] csr_val(input logic f, input logic e);
      return {24'h0, f, e, 6'h0};
   endfunction : csr_val

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'h1);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      sel <= s;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = dat_o;
      cyc <= 1'b0;
      if (n >= 50) check("wb_ack", 32'h0, 32'h1);
   endtask : wb

   task automatic expect_take(input string nm, input logic [12:0] v);
      logic [7:0] n0 = ntk;
      int n = 0;
      while (ntk === n0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      check(nm, (n < 60) ? 32'(lvec) : 32'h0, 32'(v));
   endtask : expect_take

   task automatic no_take(input string nm);
      logic [7:0] n0 = ntk;
      repeat (30) @(posedge clk);
      check(nm, 32'(ntk), 32'(n0));
   endtask : no_take

   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 80000) begin
         miscompares++;
         conclude();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'hced7));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      pwr <= 1'b0;
      repeat (3) @(posedge clk);
      check("por_pin", 32'(oe_n), 32'h0);
      repeat (4000) @(posedge clk);
      check("por_hold", 32'(irst), 32'h1);
      repeat (80) @(posedge clk);
      check("por_end", 32'(irst), 32'h0);
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         wb(1'b1, 8'h48, {r[31:8], 1'b1, r[6:0]});
         wb(1'b0, 8'h48, 32'h0);
         check("csr_rw", rdat, csr_val(1'b0, r[6]));
      end
      wb(1'b1, 8'h48, {24'h0, 1'b1, ~r[6], 6'h0}, 4'he);
      wb(1'b0, 8'h48, 32'h0);
      check("sel_off", rdat, csr_val(1'b0, r[6]));
      wb(1'b0, 8'h80, 32'h0);
      check("unmapped", rdat, 32'h0);
      r = $urandom;
      t_of <= r[0];
      t_rt <= !r[0];
      t_en <= 1'b1;
      no_take("masked");
      wb(1'b0, 8'h4c, 32'h0);
      check("pending", rdat, 32'h2);
      mask <= 1'b0;
      expect_take("timer", VEC_TIMER);
      mask <= 1'b1;
      t_rt <= 1'b0;
      t_of <= 1'b1;
      irq_n <= 1'b0;
      repeat (2) @(posedge clk);
      irq_n <= 1'b1;
      repeat (8) @(posedge clk);
      mask <= 1'b0;
      expect_take("ext_first", VEC_EXT);
      expect_take("timer_next", VEC_TIMER);
      mask <= 1'b1;
      t_of <= 1'b0;
      {ser_f, ser_e, tw_f, tw_e} <= 4'hf;
      no_take("masked_per");
      mask <= 1'b0;
      expect_take("serial", VEC_SERIAL);
      ser_f <= 1'b0;
      expect_take("twowire", VEC_TWOWIRE);
      mask <= 1'b1;
      {tw_f, tw_e, ser_e} <= 3'h0;
      repeat (10) @(posedge clk);
      trap <= 1'b1;
      @(posedge clk);
      trap <= 1'b0;
      expect_take("trap", VEC_TRAP);
      wb(1'b1, 8'h48, 32'h80);
      k = 0;
      do begin
         wb(1'b0, 8'h48, 32'h0);
         k++;
      end while (rdat[7] !== 1'b1 && k < 15000);
      check("tick_flag", rdat, csr_val(1'b1, 1'b0));
      mask <= 1'b0;
      no_take("tick_off");
      mask <= 1'b1;
      {ser_f, ser_e} <= 2'h3;
      wb(1'b1, 8'h48, 32'hc0);
      mask <= 1'b0;
      expect_take("tick", VEC_TICK);
      wb(1'b1, 8'h48, 32'h40);
      wb(1'b0, 8'h48, 32'h0);
      check("flag_clr", rdat, csr_val(1'b0, 1'b1));
      mask <= 1'b1;
      {ser_f, ser_e} <= 2'h0;
      wdog <= 1'b1;
      repeat (3) @(posedge clk);
      check("wd_pin", 32'({pin_o, oe_n, irst}), 32'h1);
      repeat (8) @(posedge clk);
      wdog <= 1'b0;
      k = 0;
      while (msamp !== 1'b1 && k < 10) begin
         @(posedge clk);
         k++;
      end
      check("wd_mode", 32'(k < 10), 32'h1);
      repeat (5) @(posedge clk);
      wb(1'b0, 8'h48, 32'h0);
      check("csr_rst", rdat, csr_val(1'b0, 1'b0));
      wt <= 1'b1;
      @(posedge clk);
      wt <= 1'b0;
      repeat (3) @(posedge clk);
      check("wait_clk", 32'(clk_en), 32'h0);
      {ser_f, ser_e} <= 2'h3;
      k = 0;
      while (clk_en !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      check("wait_wake", 32'(k < 20), 32'h1);
      {ser_f, ser_e} <= 2'h0;
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      repeat (3) @(posedge clk);
      check("stop_osc", 32'(osc), 32'h0);
      irq_n <= 1'b0;
      k = 0;
      seen = 1'b0;
      while (clk_en !== 1'b1 && k < 4200) begin
         @(posedge clk);
         k++;
         if (tclr === 1'b1) seen = 1'b1;
      end
      irq_n <= 1'b1;
      check("stab_len", 32'(k >= 4064 && k < 4080), 32'h1);
      check("stab_clr", 32'(seen), 32'h1);
      conclude();
   end
endmodule : interrupt_reset_control_test
